// ==== rtl/pss_pkg.sv ====
// Purpose: shared constants for the pid source select block
// Assumes: 16-bit signed process values, gains with 8 fraction bits
// Notes:   function codes and register offsets live only here
package pss_pkg;

    // ========================================================
    // widths
    // ========================================================
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned FUNC_W  = 4;
    localparam int unsigned PULSE_W = 2;
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned ACC_W   = 32;
    localparam int unsigned NUM_AI  = 2;

    // ========================================================
    // analog and pulse function codes
    // ========================================================
    localparam logic [FUNC_W-1:0]  AI_FUNC_FEEDBACK = 4'h8;
    localparam logic [FUNC_W-1:0]  AI_FUNC_TARGET   = 4'h9;
    localparam logic [FUNC_W-1:0]  AI_FUNC_DIFF     = 4'ha;
    localparam logic [PULSE_W-1:0] PI_FUNC_FEEDBACK = 2'h1;
    localparam logic [PULSE_W-1:0] PI_FUNC_TARGET   = 2'h2;

    // ========================================================
    // serial register map
    // ========================================================
    localparam logic [ADDR_W-1:0] REG_PID_TARGET_VALUE   = 4'h6;
    localparam logic [ADDR_W-1:0] REG_BUS_CONTROL_SELECT = 4'hf;
    localparam int unsigned       CTRL_PID_TARGET_BIT    = 1;
    localparam logic [DATA_W-1:0] REG_RESET_VALUE        = 16'h0000;

    // ========================================================
    // arithmetic
    // ========================================================
    localparam int unsigned GAIN_FRAC = 8; // gains are unsigned q8.8

    // target source codes reported on o_target_source
    typedef enum logic [2:0] {
        PSS_SRC_NONE   = 3'h0,
        PSS_SRC_AI1    = 3'h1,
        PSS_SRC_AI2    = 3'h2,
        PSS_SRC_PULSE  = 3'h3,
        PSS_SRC_PARAM  = 3'h4,
        PSS_SRC_SERIAL = 3'h5
    } pss_src_t;

endpackage

// ==== rtl/pss_terms.sv ====
// Purpose: proportional, integral and derivative terms of the deviation
// Assumes: i_sample marks one control period; gains unsigned q8.8
// Notes:   products saturate to 16 bits; integral saturates at 32 bits
`timescale 1ns/1ps
module pss_terms
    import pss_pkg::*;
(
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    input  wire logic                     i_sample,
    input  wire logic signed [DATA_W-1:0] i_deviation,
    input  wire logic        [DATA_W-1:0] i_p_gain,
    input  wire logic        [DATA_W-1:0] i_i_gain,
    input  wire logic        [DATA_W-1:0] i_d_gain,
    output logic signed      [DATA_W-1:0] o_p_term,
    output logic signed      [DATA_W-1:0] o_i_term,
    output logic signed      [DATA_W-1:0] o_d_term,
    output logic signed      [DATA_W-1:0] o_pid_input
);

    localparam int unsigned PROD_W = 2 * DATA_W + 1;

    // ========================================================
    // helpers
    // ========================================================
    // gain times value, scaled back by the fraction bits
    function automatic logic signed [PROD_W-1:0] scale(
        input logic [DATA_W-1:0] gain,
        input logic signed [DATA_W:0] val
    );
        logic signed [PROD_W-1:0] prod;
        prod = $signed({1'b0, gain}) * val;
        return prod >>> GAIN_FRAC;
    endfunction

    // clamp a wide signed value into the data width
    function automatic logic signed [DATA_W-1:0] sat(
        input logic signed [ACC_W+1:0] v
    );
        logic signed [ACC_W+1:0] hi;
        logic signed [ACC_W+1:0] lo;
        hi = (ACC_W+2)'({1'b0, {(DATA_W-1){1'b1}}});
        lo = -hi - (ACC_W+2)'(1);
        if (v > hi)
            return hi[DATA_W-1:0];
        else if (v < lo)
            return lo[DATA_W-1:0];
        else
            return v[DATA_W-1:0];
    endfunction

    logic signed [DATA_W-1:0] prev_q,  prev_d;
    logic signed [ACC_W-1:0]  acc_q,   acc_d;
    logic signed [DATA_W-1:0] p_q,     p_d;
    logic signed [DATA_W-1:0] i_q,     i_d;
    logic signed [DATA_W-1:0] dt_q,    dt_d;
    logic signed [DATA_W-1:0] in_q,    in_d;

    // ========================================================
    // next values
    // ========================================================
    // terms advance once per sample strobe and hold otherwise
    always_comb begin
        logic signed [DATA_W:0]   slope;
        logic signed [PROD_W-1:0] inc;
        logic signed [ACC_W+1:0]  sum;
        logic signed [ACC_W+1:0]  dterm;
        logic signed [ACC_W-1:0]  amax;
        slope  = '0;
        inc    = PROD_W'(0);
        sum    = (ACC_W+2)'(0);
        dterm  = (ACC_W+2)'(0);
        amax   = {1'b0, {(ACC_W-1){1'b1}}};
        prev_d = prev_q;
        acc_d  = acc_q;
        p_d    = p_q;
        i_d    = i_q;
        dt_d   = dt_q;
        in_d   = in_q;
        if (i_sample) begin
            // gain applied linearly to the deviation
            p_d = sat((ACC_W+2)'(scale(i_p_gain,
                                       (DATA_W+1)'(i_deviation))));
            // integral adds the scaled deviation on each sample strobe, saturating at 32 bits
            inc = scale(i_i_gain, (DATA_W+1)'(i_deviation));
            sum = (ACC_W+2)'(acc_q) + (ACC_W+2)'(inc);
            if (sum > (ACC_W+2)'(amax))
                acc_d = amax;
            else if (sum < -(ACC_W+2)'(amax))
                acc_d = -amax;
            else
                acc_d = sum[ACC_W-1:0];
            i_d   = sat((ACC_W+2)'(acc_d));
            // time constant times slope, added to the pid input
            slope = (DATA_W+1)'(i_deviation) - (DATA_W+1)'(prev_q);
            dterm = (ACC_W+2)'(scale(i_d_gain, slope));
            dt_d  = sat(dterm);
            in_d  = sat((ACC_W+2)'(i_deviation) + dterm);
            prev_d = i_deviation;
        end
    end

    // registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev_q <= '0;
            acc_q  <= '0;
            p_q    <= '0;
            i_q    <= '0;
            dt_q   <= '0;
            in_q   <= '0;
        end else begin
            prev_q <= prev_d;
            acc_q  <= acc_d;
            p_q    <= p_d;
            i_q    <= i_d;
            dt_q   <= dt_d;
            in_q   <= in_d;
        end
    end

    assign o_p_term    = p_q;
    assign o_i_term    = i_q;
    assign o_d_term    = dt_q;
    assign o_pid_input = in_q;

endmodule

// ==== rtl/pss_source_select.sv ====
// Purpose: pick pid target and feedback sources, flag conflicts, form terms
// Assumes: all inputs synchronous to i_clock; serial port is one master
// Notes:   Notes on behaviour listed below
//
// Notes on behaviour
// - analog function code 9 gives target source
// - pulse function code 2 gives target source
// - parameter enable 1 uses stored target value
// - serial control bit 1 uses target register
// - target priority ai1, ai2, pulse, parameter, serial
// - both analogs code 9 raise config fault
// - analog code 8 or pulse 1 is feedback
// - feedback priority ai1, ai2, then pulse
// - both analogs code 8 raise config fault
// - analog code 10 enables differential feedback
// - several differential sources raise config fault
// - proportional term is gain times deviation
// - integral term accumulates deviation over time
// - derivative term adds scaled slope to input
`timescale 1ns/1ps
module pss_source_select
    import pss_pkg::*;
(
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    // process values
    input  wire logic signed [DATA_W-1:0] i_first_analog_input,
    input  wire logic signed [DATA_W-1:0] i_second_analog_input,
    input  wire logic signed [DATA_W-1:0] i_pulse_train_input,
    // function settings
    input  wire logic [FUNC_W-1:0]        i_first_analog_function_select,
    input  wire logic [FUNC_W-1:0]        i_second_analog_function_select,
    input  wire logic [PULSE_W-1:0]       i_pulse_input_function_select,
    input  wire logic                     i_target_parameter_enable,
    input  wire logic signed [DATA_W-1:0] i_target_parameter_value,
    // gains and sample strobe
    input  wire logic [DATA_W-1:0]        i_p_gain,
    input  wire logic [DATA_W-1:0]        i_i_gain,
    input  wire logic [DATA_W-1:0]        i_d_gain,
    input  wire logic                     i_sample,
    // serial register port
    input  wire logic                     i_reg_write,
    input  wire logic [ADDR_W-1:0]        i_reg_addr,
    input  wire logic [DATA_W-1:0]        i_reg_wdata,
    output logic [DATA_W-1:0]             o_reg_rdata,
    // results
    output logic signed [DATA_W-1:0]      o_target,
    output logic [2:0]                    o_target_source,
    output logic                          o_target_valid,
    output logic signed [DATA_W-1:0]      o_feedback,
    output logic                          o_feedback_valid,
    output logic                          o_diff_feedback_active,
    output logic signed [DATA_W-1:0]      o_deviation,
    output logic                          o_analog_config_fault,
    output logic signed [DATA_W-1:0]      o_p_term,
    output logic signed [DATA_W-1:0]      o_i_term,
    output logic signed [DATA_W-1:0]      o_d_term,
    output logic signed [DATA_W-1:0]      o_pid_input
);

    // ========================================================
    // per analog channel decode
    // ========================================================
    logic        [FUNC_W-1:0] ai_func [NUM_AI];
    logic signed [DATA_W-1:0] ai_val  [NUM_AI];
    logic        [NUM_AI-1:0] ai_tgt;
    logic        [NUM_AI-1:0] ai_fb;
    logic        [NUM_AI-1:0] ai_dif;

    assign ai_func[0] = i_first_analog_function_select;
    assign ai_func[1] = i_second_analog_function_select;
    assign ai_val[0]  = i_first_analog_input;
    assign ai_val[1]  = i_second_analog_input;

    // each terminal's function code decodes to its role
    for (genvar g = 0; g < NUM_AI; g++) begin : g_ai
        assign ai_tgt[g] = (ai_func[g] == AI_FUNC_TARGET);
        assign ai_fb[g]  = (ai_func[g] == AI_FUNC_FEEDBACK);
        assign ai_dif[g] = (ai_func[g] == AI_FUNC_DIFF);
    end

    logic pi_tgt;
    logic pi_fb;
    assign pi_tgt = (i_pulse_input_function_select == PI_FUNC_TARGET);
    assign pi_fb  = (i_pulse_input_function_select == PI_FUNC_FEEDBACK);

    // ========================================================
    // serial registers
    // ========================================================
    logic [DATA_W-1:0] tgt_reg_q,  tgt_reg_d;
    logic [DATA_W-1:0] ctrl_reg_q, ctrl_reg_d;
    logic [DATA_W-1:0] rdata_q,    rdata_d;

    // writes store, reads answer on the next edge, unmapped reads zero
    always_comb begin
        tgt_reg_d  = tgt_reg_q;
        ctrl_reg_d = ctrl_reg_q;
        if (i_reg_write && i_reg_addr == REG_PID_TARGET_VALUE)
            tgt_reg_d = i_reg_wdata;
        if (i_reg_write && i_reg_addr == REG_BUS_CONTROL_SELECT)
            ctrl_reg_d = i_reg_wdata;
        case (i_reg_addr)
            REG_PID_TARGET_VALUE:   rdata_d = tgt_reg_q;
            REG_BUS_CONTROL_SELECT: rdata_d = ctrl_reg_q;
            default:                rdata_d = '0;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tgt_reg_q  <= REG_RESET_VALUE;
            ctrl_reg_q <= REG_RESET_VALUE;
            rdata_q    <= REG_RESET_VALUE;
        end else begin
            tgt_reg_q  <= tgt_reg_d;
            ctrl_reg_q <= ctrl_reg_d;
            rdata_q    <= rdata_d;
        end
    end

    // ========================================================
    // source selection and fault
    // ========================================================
    logic signed [DATA_W-1:0] target_q,  target_d;
    logic [2:0]               src_q,     src_d;
    logic                     tvalid_q,  tvalid_d;
    logic signed [DATA_W-1:0] fb_q,      fb_d;
    logic                     fvalid_q,  fvalid_d;
    logic                     dact_q,    dact_d;
    logic signed [DATA_W-1:0] dev_q,     dev_d;
    logic                     fault_q,   fault_d;

    always_comb begin
        logic signed [DATA_W-1:0] dif_val;
        logic signed [DATA_W:0]   eff_fb;
        logic signed [DATA_W+1:0] dev_w;
        logic signed [DATA_W+1:0] dmax;
        dif_val  = '0;
        dmax     = (DATA_W+2)'({1'b0, {(DATA_W-1){1'b1}}});
        target_d = '0;
        src_d    = PSS_SRC_NONE;
        tvalid_d = 1'b1;
        // fixed target priority, highest first
        if (ai_tgt[0]) begin
            target_d = ai_val[0];
            src_d    = PSS_SRC_AI1;
        end else if (ai_tgt[1]) begin
            target_d = ai_val[1];
            src_d    = PSS_SRC_AI2;
        end else if (pi_tgt) begin
            target_d = i_pulse_train_input;
            src_d    = PSS_SRC_PULSE;
        end else if (i_target_parameter_enable) begin
            target_d = i_target_parameter_value;
            src_d    = PSS_SRC_PARAM;
        end else if (ctrl_reg_q[CTRL_PID_TARGET_BIT]) begin
            target_d = $signed(tgt_reg_q);
            src_d    = PSS_SRC_SERIAL;
        end else begin
            tvalid_d = 1'b0;
        end
        // main feedback priority
        fvalid_d = 1'b1;
        if (ai_fb[0])
            fb_d = ai_val[0];
        else if (ai_fb[1])
            fb_d = ai_val[1];
        else if (pi_fb)
            fb_d = i_pulse_train_input;
        else begin
            fb_d     = '0;
            fvalid_d = 1'b0;
        end
        // differential feedback joins the deviation when assigned
        dact_d = |ai_dif;
        if (ai_dif[0])
            dif_val = ai_val[0];
        else if (ai_dif[1])
            dif_val = ai_val[1];
        eff_fb = (DATA_W+1)'(fb_d) - (DATA_W+1)'(dif_val);
        dev_w  = (DATA_W+2)'(target_d) - (DATA_W+2)'(eff_fb);
        if (dev_w > dmax)
            dev_d = dmax[DATA_W-1:0];
        else if (dev_w < -dmax - (DATA_W+2)'(1))
            dev_d = {1'b1, {(DATA_W-1){1'b0}}};
        else
            dev_d = dev_w[DATA_W-1:0];
        // fault follows the settings, clearing once corrected
        fault_d = (&ai_tgt)
                | (&ai_fb)
                | (&ai_dif);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            target_q <= '0;
            src_q    <= PSS_SRC_NONE;
            tvalid_q <= 1'b0;
            fb_q     <= '0;
            fvalid_q <= 1'b0;
            dact_q   <= 1'b0;
            dev_q    <= '0;
            fault_q  <= 1'b0;
        end else begin
            target_q <= target_d;
            src_q    <= src_d;
            tvalid_q <= tvalid_d;
            fb_q     <= fb_d;
            fvalid_q <= fvalid_d;
            dact_q   <= dact_d;
            dev_q    <= dev_d;
            fault_q  <= fault_d;
        end
    end

    // ========================================================
    // pid terms
    // ========================================================
    pss_terms u_terms (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_sample    (i_sample),
        .i_deviation (dev_q),
        .i_p_gain    (i_p_gain),
        .i_i_gain    (i_i_gain),
        .i_d_gain    (i_d_gain),
        .o_p_term    (o_p_term),
        .o_i_term    (o_i_term),
        .o_d_term    (o_d_term),
        .o_pid_input (o_pid_input)
    );

    // outputs straight from flops
    assign o_reg_rdata            = rdata_q;
    assign o_target               = target_q;
    assign o_target_source        = src_q;
    assign o_target_valid         = tvalid_q;
    assign o_feedback             = fb_q;
    assign o_feedback_valid       = fvalid_q;
    assign o_diff_feedback_active = dact_q;
    assign o_deviation            = dev_q;
    assign o_analog_config_fault  = fault_q;

endmodule

// ==== test/pss_properties.sv ====
// Purpose: port checks for the pid source select block
// Assumes: one clock, async active-high reset
// Notes:   the bench holds every select at zero during reset
`timescale 1ns/1ps
module pss_properties
    import pss_pkg::*;
(
    input wire logic                     i_clock,
    input wire logic                     i_rst,
    input wire logic [FUNC_W-1:0]        i_first_analog_function_select,
    input wire logic [FUNC_W-1:0]        i_second_analog_function_select,
    input wire logic [PULSE_W-1:0]       i_pulse_input_function_select,
    input wire logic signed [DATA_W-1:0] i_first_analog_input,
    input wire logic                     i_sample,
    input wire logic [DATA_W-1:0]        i_p_gain,
    input wire logic [DATA_W-1:0]        i_d_gain,
    input wire logic signed [DATA_W-1:0] o_target,
    input wire logic [2:0]               o_target_source,
    input wire logic signed [DATA_W-1:0] o_feedback,
    input wire logic                     o_diff_feedback_active,
    input wire logic signed [DATA_W-1:0] o_deviation,
    input wire logic                     o_analog_config_fault,
    input wire logic signed [DATA_W-1:0] o_p_term,
    input wire logic signed [DATA_W-1:0] o_i_term,
    input wire logic signed [DATA_W-1:0] o_d_term,
    input wire logic signed [DATA_W-1:0] o_pid_input
);
    // =====
    // short names for the two analog selects
    wire logic [FUNC_W-1:0] f1 = i_first_analog_function_select;
    wire logic [FUNC_W-1:0] f2 = i_second_analog_function_select;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // =====
    // relations one cycle after the cause
    tgt_ai1_a: assert property (f1 == AI_FUNC_TARGET |=>
        o_target_source == 3'h1 && o_target == $past(i_first_analog_input))
        else $error("ai1 target");
    tgt_pulse_a: assert property (f1 != AI_FUNC_TARGET &&
        f2 != AI_FUNC_TARGET && i_pulse_input_function_select ==
        PI_FUNC_TARGET |=> o_target_source == 3'h3)
        else $error("pulse target");
    flt_target_a: assert property (f1 == f2 && f1 == AI_FUNC_TARGET
        |=> o_analog_config_fault) else $error("double target");
    flt_fb_a: assert property (f1 == f2 && f1 == AI_FUNC_FEEDBACK
        |=> o_analog_config_fault) else $error("double fb");
    flt_diff_a: assert property (f1 == f2 && f1 == AI_FUNC_DIFF
        |=> o_analog_config_fault) else $error("double diff");
    flt_clear_a: assert property (f1 != f2 |=> !o_analog_config_fault)
        else $error("stray fault");
    fb_ai1_a: assert property (f1 == AI_FUNC_FEEDBACK |=>
        o_feedback == $past(i_first_analog_input))
        else $error("ai1 feedback");
    diff_on_a: assert property (f1 == AI_FUNC_DIFF || f2 == AI_FUNC_DIFF
        |=> o_diff_feedback_active) else $error("diff idle");
    p_unity_a: assert property (i_sample && i_p_gain == 16'h0100 |=>
        o_p_term == $past(o_deviation)) else $error("p term");
    i_hold_a: assert property (!i_sample |=> $stable(o_i_term))
        else $error("i moved");
    d_zero_a: assert property (i_sample && i_d_gain == 16'h0000 |=>
        o_d_term == 16'h0000 && o_pid_input == $past(o_deviation))
        else $error("d term");
    c_fault: cover property ($rose(o_analog_config_fault));
    c_serial: cover property (o_target_source == 3'h5);
    c_diff: cover property (o_diff_feedback_active && f1 == AI_FUNC_FEEDBACK);
endmodule

bind pss_source_select pss_properties pss_properties_inst (
    .i_clock, .i_rst, .i_first_analog_function_select,
    .i_second_analog_function_select, .i_pulse_input_function_select,
    .i_first_analog_input, .i_sample, .i_p_gain, .i_d_gain, .o_target,
    .o_target_source, .o_feedback, .o_diff_feedback_active, .o_deviation,
    .o_analog_config_fault, .o_p_term, .o_i_term, .o_d_term, .o_pid_input
);

// ==== test/pss_field_model.sv ====
// Purpose: sensors, pulse input and serial master facing the block
// Assumes: sensor values are levels; one serial master
// Notes:   idle write data shows the inverse of the last word
`timescale 1ns/1ps
module pss_field_model
    import pss_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic [DATA_W-1:0]   i_reg_rdata,
    output logic signed [DATA_W-1:0] o_ai1,
    output logic signed [DATA_W-1:0] o_ai2,
    output logic signed [DATA_W-1:0] o_pulse,
    output logic                     o_reg_write,
    output logic [ADDR_W-1:0]        o_reg_addr,
    output logic [DATA_W-1:0]        o_reg_wdata
);
    // quiet lines at time zero
    initial begin
        o_ai1 = '0;
        o_ai2 = '0;
        o_pulse = '0;
        o_reg_write = 1'b0;
        o_reg_addr = '0;
        o_reg_wdata = '0;
    end

    // new sensor levels after an edge
    task automatic set_values(input logic signed [DATA_W-1:0] a, b, p);
        @(posedge i_clock);
        o_ai1 <= a;
        o_ai2 <= b;
        o_pulse <= p;
    endtask

    // one strobe cycle, then the inverse of the written word
    task automatic bus_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge i_clock);
        o_reg_write <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_clock);
        o_reg_write <= 1'b0;
        o_reg_wdata <= ~d;
    endtask

    // address held until the answer settles
    task automatic bus_read(input logic [ADDR_W-1:0] a,
                            output logic [DATA_W-1:0] d);
        @(posedge i_clock);
        o_reg_addr <= a;
        repeat (2) @(posedge i_clock);
        #1 d = i_reg_rdata;
    endtask
endmodule

// ==== test/pss_source_select_tb.sv ====
// Purpose: random and corner checks of the pid source select block
// Assumes: process values stay small so no sum saturates
// Notes:   expected values come from the bench functions
`timescale 1ns/1ps
module pss_source_select_tb
    import pss_pkg::*;
;
    // =====
    // stimulus, results and counters
    localparam logic [3:0] CODES [5] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'ha};
    localparam logic [3:0] ADDRS [3] = '{4'h6, 4'hf, 4'h3};
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic [3:0]  f1   = '0;
    logic [3:0]  f2   = '0;
    logic [1:0]  pf   = '0;
    logic        en   = 1'b0;
    logic        smp  = 1'b0;
    logic [15:0] pv   = '0;
    logic [15:0] kp   = '0;
    logic [15:0] ki   = '0;
    logic [15:0] kd   = '0;
    logic [15:0] reg6 = '0;
    logic [15:0] ctrl = '0;
    logic [15:0] a1, a2, pl, wd, rd, r, o_tgt, o_fb, o_dev, o_p, o_i;
    logic [15:0] o_d, o_pin;
    logic [3:0]  ad;
    logic [2:0]  o_src;
    logic        wr, o_tv, o_fv, o_dv, o_flt;
    int          fail_count, compares, cyc, acc, dp, dv, d;

    always #12.5 clk = ~clk;

    // =====
    // design and far side
    pss_source_select pss_source_select_inst (
        .i_clock(clk), .i_rst(rst), .i_first_analog_input(a1),
        .i_second_analog_input(a2), .i_pulse_train_input(pl),
        .i_first_analog_function_select(f1),
        .i_second_analog_function_select(f2),
        .i_pulse_input_function_select(pf),
        .i_target_parameter_enable(en), .i_target_parameter_value(pv),
        .i_p_gain(kp), .i_i_gain(ki), .i_d_gain(kd), .i_sample(smp),
        .i_reg_write(wr), .i_reg_addr(ad), .i_reg_wdata(wd),
        .o_reg_rdata(rd), .o_target(o_tgt), .o_target_source(o_src),
        .o_target_valid(o_tv), .o_feedback(o_fb), .o_feedback_valid(o_fv),
        .o_diff_feedback_active(o_dv), .o_deviation(o_dev),
        .o_analog_config_fault(o_flt), .o_p_term(o_p), .o_i_term(o_i),
        .o_d_term(o_d), .o_pid_input(o_pin));
    pss_field_model pss_field_model_inst (
        .i_clock(clk), .i_reg_rdata(rd), .o_ai1(a1), .o_ai2(a2),
        .o_pulse(pl), .o_reg_write(wr), .o_reg_addr(ad), .o_reg_wdata(wd));

    // =====
    // expectation helpers
    function automatic logic [15:0] rv();
        return 16'($urandom_range(8191)) - 16'h1000;
    endfunction

    function automatic logic [2:0] exp_src();
        if (f1 == AI_FUNC_TARGET) return 3'h1;
        if (f2 == AI_FUNC_TARGET) return 3'h2;
        if (pf == PI_FUNC_TARGET) return 3'h3;
        if (en) return 3'h4;
        if (ctrl[1]) return 3'h5;
        return 3'h0;
    endfunction

    function automatic logic [15:0] src_val(input logic [2:0] s);
        case (s)
            3'h1: return a1;
            3'h2: return a2;
            3'h3: return pl;
            3'h4: return pv;
            3'h5: return reg6;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check_val(input logic [15:0] got, exp, input string w);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask

    // all selection outputs against the current settings
    task automatic check_sel();
        logic [2:0]  ts;
        logic [2:0]  fs;
        logic [15:0] df;
        ts = exp_src();
        fs = (f1 == AI_FUNC_FEEDBACK) ? 3'h1 : (f2 == AI_FUNC_FEEDBACK) ?
             3'h2 : (pf == PI_FUNC_FEEDBACK) ? 3'h3 : 3'h0;
        df = (f1 == AI_FUNC_DIFF) ? a1 : (f2 == AI_FUNC_DIFF) ? a2 : 16'h0;
        check_val(16'(o_src), 16'(ts), "src");
        check_val(16'(o_tv), 16'(ts != 3'h0), "tv");
        if (ts != 3'h0) check_val(o_tgt, src_val(ts), "target");
        if (ts != 3'h0) check_val(o_dev, src_val(ts) - (src_val(fs) - df),
                                  "dev");
        if (fs != 3'h0) check_val(o_fb, src_val(fs), "fb");
        check_val(16'(o_fv), 16'(fs != 3'h0), "fv");
        check_val(16'(o_dv), 16'(f1 == AI_FUNC_DIFF || f2 == AI_FUNC_DIFF),
                  "diff");
        check_val(16'(o_flt), 16'(f1 == f2 && (f1 == AI_FUNC_FEEDBACK ||
                  f1 == AI_FUNC_TARGET || f1 == AI_FUNC_DIFF)),
                  "fault");
    endtask

    task automatic apply(input logic [3:0] a, b, input logic [1:0] p,
                         input logic e);
        @(posedge clk);
        f1 <= a;
        f2 <= b;
        pf <= p;
        en <= e;
        pv <= rv();
        pss_field_model_inst.set_values(rv(), rv(), rv());
        repeat (3) @(posedge clk);
        #1 check_sel();
    endtask

    task automatic read_all();
        foreach (ADDRS[k]) begin
            pss_field_model_inst.bus_read(ADDRS[k], r);
            check_val(r, (ADDRS[k] == 4'h6) ? reg6 : (ADDRS[k] == 4'hf) ?
                      ctrl : 16'h0000, "rdata");
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // cycle ceiling against a hung run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // =====
    // main sequence
    initial begin
        void'($urandom(32'hc1058ba9));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        read_all();
        pss_field_model_inst.bus_write(4'h3, 16'h5a5a);
        reg6 = 16'h0123;
        ctrl = 16'h0002;
        pss_field_model_inst.bus_write(4'h6, reg6);
        pss_field_model_inst.bus_write(4'hf, ctrl);
        read_all();
        // doubled selections raise the fault, which drops once fixed
        for (int k = 8; k <= 10; k++) begin
            apply(4'(k), 4'(k), 2'h0, 1'b0);
            apply(4'(k), 4'h0, 2'h0, 1'b0);
        end
        for (int n = 0; n < 80; n++) begin
            if ($urandom_range(3) == 0) begin
                reg6 = rv();
                ctrl = 16'($urandom);
                pss_field_model_inst.bus_write(4'h6, reg6);
                pss_field_model_inst.bus_write(4'hf, ctrl);
            end
            apply(CODES[$urandom_range(4)], CODES[$urandom_range(4)],
                  2'($urandom), 1'($urandom));
        end
        // terms: deviation is the first analog level
        for (int k = 0; k < 4; k++) begin
            apply(AI_FUNC_TARGET, 4'h0, 2'h0, 1'b0);
            dv = int'($signed(a1));
            @(posedge clk);
            smp <= 1'b1;
            kp <= k[0] ? 16'h0180 : 16'h0100;
            ki <= 16'h0040;
            kd <= (k == 3) ? 16'h0000 : 16'h0080;
            @(posedge clk);
            smp <= 1'b0;
            @(posedge clk);
            #1 acc += (int'(ki) * dv) >>> 8;
            d = (int'(kd) * (dv - dp)) >>> 8;
            check_val(o_p, 16'((int'(kp) * dv) >>> 8), "p term");
            check_val(o_i, 16'(acc), "i term");
            check_val(o_d, 16'(d), "d term");
            check_val(o_pin, 16'(dv + d), "pin");
            dp = dv;
        end
        wrap_up();
    end
endmodule
